// file: tbc_pkg.sv
// constants shared by the 16-bit timer/counter block
package tbc_pkg;
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_LOW = 6'h01;
	localparam logic [5:0] IDX_HIGH = 6'h02;
	localparam logic [5:0] IDX_STAT = 6'h03;
	localparam int BIT_RUN = 0;
	localparam int BIT_SRC_EXT = 1;
	localparam int BIT_SYNC_BYP = 2;
	localparam int BIT_OSC_EN = 3;
	localparam int PS_LSB = 4;
	localparam int PS_MSB = 5;
	localparam int BIT_OSC_SYS = 6;
	localparam int BIT_WIDE = 7;
	localparam int BIT_WRAP = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hBF;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] HBUF_RESET = 8'h00;
	localparam logic [1:0] INST_DIV_LAST = 2'h3;
	localparam logic [2:0] PS_RESET = 3'h0;
endpackage

// file: tbc_tick_if.sv
// count-clock selection and prescaler signals between top and prescaler
interface tbc_tick_if;
	logic run;
	logic src_ext;
	logic sync_bypass;
	logic clr;
	logic [1:0] ps_sel;
	logic ext_raw;
	logic inc;
	modport ctl (output run, output src_ext, output sync_bypass, output clr,
		output ps_sel, output ext_raw, input inc);
	modport pre (input run, input src_ext, input sync_bypass, input clr,
		input ps_sel, input ext_raw, output inc);
endinterface

// file: tbc_prescaler.sv
// count source selection, external edge detection and 1/2/4/8 prescaler
module tbc_prescaler
	import tbc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	tbc_tick_if.pre tk
);
	logic s1;
	logic s2;
	logic s3;
	logic edge_q;
	logic [1:0] qdiv;
	logic [2:0] ps_cnt;
	wire edge_raw;
	wire ext_edge;
	wire inst_tick;
	wire src_tick;
	wire [2:0] ps_max;
	wire ps_wrap;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			edge_q <= 1'b0;
			qdiv <= 2'h0;
		end else begin
			s1 <= tk.ext_raw;
			s2 <= s1;
			s3 <= s2;
			edge_q <= edge_raw;
			qdiv <= qdiv + 2'h1;
		end
	end

	assign edge_raw = s2 & ~s3;
	// bypass skips the alignment stage; the pad itself still passes two flops
	assign ext_edge = tk.sync_bypass ? edge_raw : edge_q;
	assign inst_tick = (qdiv == INST_DIV_LAST);
	assign src_tick = tk.src_ext ? ext_edge : inst_tick;
	assign ps_max = {tk.ps_sel == 2'h3, tk.ps_sel[1], |tk.ps_sel};
	assign ps_wrap = (ps_cnt == ps_max);
	assign tk.inc = tk.run & src_tick & ps_wrap & ~tk.clr;

	always_ff @(posedge i_clk) begin
		if (i_rst || tk.clr) begin
			ps_cnt <= PS_RESET;
		end else if (tk.run && src_tick) begin
			ps_cnt <= ps_wrap ? PS_RESET : ps_cnt + 3'h1;
		end
	end

	a_ps_divide: assert property (@(posedge i_clk) disable iff (i_rst)
		(tk.inc && tk.ps_sel == 2'h3 && !tk.src_ext) |-> ##1 !tk.inc [*8])
		else $error("prescaler 1:8 gave increments too close together");
endmodule

// file: tbc_timer.sv
// 16-bit timer/counter with crystal oscillator control, Wishbone slave
// Overview of operation
// - counts only while count_run is set
// - wide_access_mode gives one 16-bit access
// - read-only bit shows oscillator drives system clock
// - prescale field divides by 1, 2, 4, 8
// - crystal_osc_enable powers the oscillator amplifier
// - external input always synchronized; bypass bit skips only the alignment stage
// - internal source ignores the bypass bit
// - source bit picks Fosc/4 or external edges
// - oscillator on: pins inputs, read as zero
// - two byte count registers, wrap flags overflow
// - compare_unit special event clears the count
// - oscillator keeps running in power-managed modes
// - wide mode: low read/write moves high buffer
// - wrap sets flag always, special event never
// - software write beats special event reset
// - low-byte write clears prescaler, high does not
module tbc_timer
	import tbc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_special_event,
	input wire logic i_sys_clk_from_osc,
	input wire logic i_power_managed,
	input wire logic [1:0] i_port_out,
	input wire logic [1:0] i_port_dir_in,
	input wire logic i_crystal_in_pin,
	output logic o_crystal_in_pin,
	output logic o_crystal_in_pin_oe,
	input wire logic i_crystal_out_pin,
	output logic o_crystal_out_pin,
	output logic o_crystal_out_pin_oe,
	output logic [1:0] o_port_read,
	output logic o_osc_amp_enable,
	output logic o_wrap_flag
);
	logic [7:0] ctrl;
	logic [15:0] count;
	logic [7:0] hbuf;
	logic wrap_flag;
	logic osc_s1;
	logic osc_s2;
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [31:0] rd_q;
	logic ack;
	tbc_tick_if tk ();

	wire req;
	wire take;
	wire wr;
	wire rd_take;
	wire [5:0] idx;
	wire lane0;
	wire sel_ctrl;
	wire sel_low;
	wire sel_high;
	wire sel_stat;
	wire wr_ctrl;
	wire wr_low;
	wire wr_high;
	wire wr_stat;
	wire rd_low;
	wire wide;
	wire osc_en;
	wire cnt_wr;
	wire wrap_evt;
	wire [7:0] ctrl_rd;
	wire [7:0] high_rd;
	wire [7:0] byte_rd;
	wire [15:0] count_inc;
	wire [15:0] next_count;
	wire [7:0] next_hbuf;
	wire [7:0] next_ctrl;
	wire next_wrap_flag;

	// bus decode: one word per register, byte lane 0 carries the data
	assign req = i_wb_cyc & i_wb_stb;
	assign take = req & ~ack;
	assign wr = req & ack & i_wb_we & lane0;
	assign rd_take = take & ~i_wb_we;
	assign idx = i_wb_adr[7:2];
	assign lane0 = i_wb_sel[0];
	assign sel_ctrl = (idx == IDX_CTRL);
	assign sel_low = (idx == IDX_LOW);
	assign sel_high = (idx == IDX_HIGH);
	assign sel_stat = (idx == IDX_STAT);
	assign wr_ctrl = wr & sel_ctrl;
	assign wr_low = wr & sel_low;
	assign wr_high = wr & sel_high;
	assign wr_stat = wr & sel_stat;
	assign rd_low = rd_take & sel_low;

	assign wide = ctrl[BIT_WIDE];
	assign osc_en = ctrl[BIT_OSC_EN];

	// status bit is never stored, it always mirrors the clock switch
	assign ctrl_rd = {ctrl[BIT_WIDE], osc_s2, ctrl[PS_MSB:PS_LSB], ctrl[3:0]};
	assign high_rd = wide ? hbuf : count[15:8];
	assign byte_rd = sel_ctrl ? ctrl_rd :
		sel_low ? count[7:0] :
		sel_high ? high_rd :
		sel_stat ? {7'h00, wrap_flag} : 8'h00;

	// count source and prescaler
	assign tk.run = ctrl[BIT_RUN];
	assign tk.src_ext = ctrl[BIT_SRC_EXT];
	assign tk.sync_bypass = ctrl[BIT_SYNC_BYP];
	assign tk.ps_sel = ctrl[PS_MSB:PS_LSB];
	assign tk.clr = wr_low;
	// the shared pad carries either the external clock or the crystal signal
	assign tk.ext_raw = i_crystal_out_pin;

	tbc_prescaler u_pre (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.tk(tk)
	);

	// count update: software write first, then special event, then increment
	assign cnt_wr = wr_low | (wr_high & ~wide);
	assign count_inc = count + 16'h0001;
	assign wrap_evt = tk.inc & (count == COUNT_MAX) & ~cnt_wr & ~i_special_event;
	assign next_count = wr_low ?
		{(wide ? hbuf : count[15:8]), i_wb_dat[7:0]} :
		(wr_high && !wide) ? {i_wb_dat[7:0], count[7:0]} :
		i_special_event ? COUNT_RESET :
		tk.inc ? count_inc : count;
	assign next_hbuf = (wr_high && wide) ? i_wb_dat[7:0] :
		(rd_low && wide) ? count[15:8] : hbuf;
	assign next_ctrl = (i_wb_dat[7:0] & CTRL_WMASK) | (ctrl & ~CTRL_WMASK);
	// a wrap in the clearing cycle keeps the flag set
	assign next_wrap_flag = wrap_evt | (wrap_flag & ~(wr_stat & i_wb_dat[BIT_WRAP]));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count <= COUNT_RESET;
			hbuf <= HBUF_RESET;
			wrap_flag <= 1'b0;
		end else begin
			count <= next_count;
			hbuf <= next_hbuf;
			wrap_flag <= next_wrap_flag;
		end
	end

	// oscillator enable is not gated by power-managed state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack <= 1'b0;
			rd_q <= 32'h0000_0000;
		end else begin
			ack <= take;
			rd_q <= rd_take ? {24'h00_0000, byte_rd} : 32'h0000_0000;
		end
	end

	assign o_wb_ack = ack;
	assign o_wb_dat = rd_q;

	// pad inputs and clock-switch status arrive from other domains
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
		end else begin
			osc_s1 <= i_sys_clk_from_osc;
			osc_s2 <= osc_s1;
			pin_s1 <= {i_crystal_in_pin, i_crystal_out_pin};
			pin_s2 <= pin_s1;
		end
	end

	// osc pads: enabled oscillator overrides port direction and reads zero
	assign o_crystal_out_pin = i_port_out[0];
	assign o_crystal_in_pin = i_port_out[1];
	assign o_crystal_out_pin_oe = ~osc_en & ~i_port_dir_in[0];
	assign o_crystal_in_pin_oe = ~osc_en & ~i_port_dir_in[1];
	assign o_port_read = osc_en ? 2'h0 : pin_s2;
	// start-up settling is left to software; the amplifier runs as soon as set
	assign o_osc_amp_enable = osc_en;
	assign o_wrap_flag = wrap_flag;

	a_halt_holds: assert property (@(posedge i_clk) disable iff (i_rst)
		(!ctrl[BIT_RUN] && !cnt_wr && !i_special_event) |=> count == $past(count))
		else $error("count moved while halted");
	a_wrap_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
		(count == COUNT_MAX && tk.inc && !cnt_wr && !i_special_event)
		|=> (wrap_flag && count == COUNT_RESET))
		else $error("wrap did not clear count and set flag");
	a_sev_clears: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_special_event && !cnt_wr) |=> count == COUNT_RESET)
		else $error("special event did not clear count");
	a_sev_no_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		(!wrap_flag && i_special_event) |=> !wrap_flag)
		else $error("special event set the wrap flag");
	a_write_wins: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_low && i_special_event) |=> count[7:0] == $past(i_wb_dat[7:0]))
		else $error("special event beat a low-byte write");
	a_wide_load: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_low && wide) |=> count[15:8] == $past(hbuf))
		else $error("wide write did not load high byte from buffer");
	a_wide_snap: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_low && wide) |=> hbuf == $past(count[15:8]))
		else $error("wide low read did not snapshot high byte");
	a_byte_high: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_high && !wide) |=> (count[15:8] == $past(i_wb_dat[7:0]) && hbuf == $past(hbuf)))
		else $error("byte-mode high write misrouted");
	a_osc_pins: assert property (@(posedge i_clk) disable iff (i_rst)
		osc_en |-> (!o_crystal_in_pin_oe && !o_crystal_out_pin_oe && o_port_read == 2'h0))
		else $error("oscillator pins driven or read nonzero");
	a_status_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_take && sel_ctrl) |=> o_wb_dat[BIT_OSC_SYS] == $past(osc_s2))
		else $error("clock status bit misreported");
	a_ack_single: assert property (@(posedge i_clk) disable iff (i_rst)
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");

	c_wrap: cover property (@(posedge i_clk) disable iff (i_rst) wrap_evt);
	c_wide_read: cover property (@(posedge i_clk) disable iff (i_rst) rd_low && wide);
	c_sev: cover property (@(posedge i_clk) disable iff (i_rst) i_special_event && tk.inc);
	c_ext_count: cover property (@(posedge i_clk) disable iff (i_rst) tk.src_ext && tk.inc);
endmodule

// file: tbc_ext_src.sv
// far-side model: external count pad pulses and a crystal swing
module tbc_ext_src (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_edges,
	output logic o_pad,
	output logic o_xtal,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left;
	logic [2:0] ph;
	initial begin
		o_pad = 1'b0;
		o_xtal = 1'b0;
		left = 8'h00;
		ph = 3'h0;
	end
	assign o_busy = (left != 8'h00) || i_go;
	always @(posedge i_clk) begin
		// crystal never stands still, so a stale level cannot pass for a read
		o_xtal <= ~o_xtal;
		if (i_go) begin
			left <= i_edges;
			ph <= 3'h0;
		end else if (left != 8'h00) begin
			ph <= ph + 3'h1;
			// four cycles per level so the two-flop path sees every edge
			if (ph == 3'h3)
				o_pad <= 1'b1;
			if (ph == 3'h7) begin
				o_pad <= 1'b0;
				left <= left - 8'h01;
			end
		end
	end
endmodule

// file: test_tbc_timer.sv
// self-checking bench for the timer/counter over Wishbone
module test_tbc_timer;
	timeunit 1ns;
	timeprecision 1ns;
	import tbc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_special_event, i_sys_clk_from_osc;
	logic i_power_managed, o_wb_ack, o_crystal_in_pin, o_crystal_in_pin_oe;
	logic o_crystal_out_pin, o_crystal_out_pin_oe, o_osc_amp_enable, o_wrap_flag;
	logic [7:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [31:0] i_wb_dat, o_wb_dat;
	logic [1:0] i_port_out, i_port_dir_in, o_port_read;
	logic go, pad, xtal, busy;
	logic [7:0] edges;
	logic [7:0] exp_q[$];
	wire i_crystal_in_pin = o_crystal_in_pin_oe ? o_crystal_in_pin : xtal;
	wire i_crystal_out_pin = o_crystal_out_pin_oe ? o_crystal_out_pin : pad;
	int fails, compares, seed;
	tbc_timer dut (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
		.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_special_event, .i_sys_clk_from_osc,
		.i_power_managed, .i_port_out, .i_port_dir_in, .i_crystal_in_pin,
		.o_crystal_in_pin, .o_crystal_in_pin_oe, .i_crystal_out_pin, .o_crystal_out_pin,
		.o_crystal_out_pin_oe, .o_port_read, .o_osc_amp_enable, .o_wrap_flag);
	tbc_ext_src far (.i_clk(i_clk), .i_go(go), .i_edges(edges), .o_pad(pad),
		.o_xtal(xtal), .o_busy(busy));
	always #10 i_clk = ~i_clk;
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		@(posedge i_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= {idx, 2'b00};
		i_wb_sel <= 4'hF;
		i_wb_dat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		if (o_wb_ack !== 1'b1) begin
			fails++;
			stop_test();
		end
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask
	task rd(input logic [5:0] idx, input logic [7:0] exp);
		exp_q.push_back(exp);
		wb(1'b0, idx, 8'h00);
	endtask
	task pulse(input logic [7:0] n_edges);
		int n;
		go <= 1'b1;
		edges <= n_edges;
		@(posedge i_clk);
		go <= 1'b0;
		n = 0;
		while (busy === 1'b1 && n < 600) begin
			@(posedge i_clk);
			n++;
		end
		if (busy === 1'b1) begin
			fails++;
			stop_test();
		end
		repeat (6) @(posedge i_clk);
	endtask
	always @(posedge i_clk) begin
		if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
			if (exp_q.size() == 0)
				check("unexpected read", o_wb_dat, 32'hFFFFFFFF);
			else
				check("read data", o_wb_dat, {24'h000000, exp_q.pop_front()});
		end
	end
	initial begin
		seed = 32'hcda2;
		fails = 0;
		compares = 0;
		{i_wb_cyc, i_wb_stb, i_wb_we, i_special_event, i_sys_clk_from_osc} = 5'h00;
		{i_wb_adr, i_wb_sel, i_wb_dat, i_power_managed, go, edges} = '0;
		i_port_out = 2'($random(seed));
		// count pad must stay an input so the far side owns it
		i_port_dir_in = 2'h3;
		i_rst = 1'b1;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(IDX_CTRL, CTRL_RESET);
		rd(IDX_LOW, 8'h00);
		rd(IDX_HIGH, 8'h00);
		rd(IDX_STAT, 8'h00);
		rd(6'h05, 8'h00);
		wb(1'b1, IDX_LOW, 8'hA5);
		repeat (40) @(posedge i_clk);
		rd(IDX_LOW, 8'hA5);
		for (int ps = 0; ps < 4; ps++) begin
			wb(1'b1, IDX_CTRL, {2'b00, 2'(ps), 1'b0, 1'($random(seed)), 2'b11});
			wb(1'b1, IDX_HIGH, 8'h00);
			wb(1'b1, IDX_LOW, 8'h00);
			pulse(8'h18);
			rd(IDX_LOW, 8'h18 >> ps);
		end
		wb(1'b1, IDX_CTRL, 8'h13);
		wb(1'b1, IDX_LOW, 8'h00);
		pulse(8'h01);
		wb(1'b1, IDX_HIGH, 8'h00);
		pulse(8'h01);
		rd(IDX_LOW, 8'h01);
		// internal clock at 1:8 with bypass set: 145 edges hold 36 or 37 ticks
		wb(1'b1, IDX_CTRL, 8'h35);
		wb(1'b1, IDX_LOW, 8'h00);
		repeat (144) @(posedge i_clk);
		rd(IDX_LOW, 8'h04);
		wb(1'b1, IDX_CTRL, 8'h03);
		wb(1'b1, IDX_HIGH, 8'hFF);
		wb(1'b1, IDX_LOW, 8'hFF);
		pulse(8'h01);
		rd(IDX_LOW, 8'h00);
		rd(IDX_HIGH, 8'h00);
		rd(IDX_STAT, 8'h01);
		check("wrap pin", o_wrap_flag, 32'h1);
		wb(1'b1, IDX_STAT, 8'h01);
		rd(IDX_STAT, 8'h00);
		wb(1'b1, IDX_LOW, 8'h55);
		i_special_event <= 1'b1;
		@(posedge i_clk);
		i_special_event <= 1'b0;
		rd(IDX_LOW, 8'h00);
		rd(IDX_STAT, 8'h00);
		i_special_event <= 1'b1;
		wb(1'b1, IDX_LOW, 8'h3C);
		i_special_event <= 1'b0;
		rd(IDX_LOW, 8'h3C);
		wb(1'b1, IDX_CTRL, 8'h80);
		rd(IDX_CTRL, 8'h80);
		wb(1'b1, IDX_HIGH, 8'h12);
		wb(1'b1, IDX_LOW, 8'h34);
		rd(IDX_LOW, 8'h34);
		rd(IDX_HIGH, 8'h12);
		wb(1'b1, IDX_HIGH, 8'h77);
		rd(IDX_LOW, 8'h34);
		rd(IDX_HIGH, 8'h12);
		i_sys_clk_from_osc <= 1'b1;
		repeat (4) @(posedge i_clk);
		rd(IDX_CTRL, 8'hC0);
		wb(1'b1, IDX_CTRL, 8'h08);
		rd(IDX_CTRL, 8'h48);
		check("amp", o_osc_amp_enable, 32'h1);
		// pads set to outputs: only the running oscillator keeps them released
		i_port_dir_in <= 2'h0;
		// software start-up delay before relying on the oscillator
		repeat (50) @(posedge i_clk);
		check("pin drive", {o_crystal_in_pin_oe, o_crystal_out_pin_oe}, 32'h0);
		check("port read", o_port_read, 32'h0);
		i_power_managed <= 1'b1;
		repeat (4) @(posedge i_clk);
		check("amp held", o_osc_amp_enable, 32'h1);
		wb(1'b1, IDX_CTRL, 8'h00);
		@(posedge i_clk);
		check("amp off", o_osc_amp_enable, 32'h0);
		repeat (2) @(posedge i_clk);
		check("pin drive off", {o_crystal_in_pin_oe, o_crystal_out_pin_oe}, 32'h3);
		check("pin out", {o_crystal_in_pin, o_crystal_out_pin}, {30'h0, i_port_out});
		check("port read off", o_port_read, {30'h0, i_port_out});
		stop_test();
	end
endmodule
